// File: logic/cg_pkg.sv
package cg_pkg;
  // ****************************************
  // Register map and layout
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SRC_CTRL = 8'h00;
  localparam logic [7:0] OFF_OSC_DIV = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] RST_SRC_CTRL = 8'h04;
  localparam logic [7:0] RST_OSC_DIV = 8'h40;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [8:0] TRIM_DEBUG_DEFAULT = 9'h100;
  // clock_source_control fields
  localparam int SRC_SEL_HI = 7;
  localparam int SRC_SEL_LO = 6;
  localparam int REF_DIV_HI = 5;
  localparam int REF_DIV_LO = 3;
  localparam int INT_REF_SEL = 2;
  localparam int INT_REF_EN = 1;
  localparam int INT_REF_STOP_EN = 0;
  // oscillator_divider_control fields
  localparam int BUS_DIV_HI = 7;
  localparam int BUS_DIV_LO = 6;
  localparam int RANGE_BIT = 5;
  localparam int HIGH_GAIN = 4;
  localparam int LOW_POWER = 3;
  localparam int EXT_REF_KIND = 2;
  localparam int EXT_REF_EN = 1;
  localparam int EXT_REF_STOP_EN = 0;
  // loop_status_control fields
  localparam int OSC_RANGE_HI = 7;
  localparam int OSC_RANGE_LO = 6;
  localparam int MAX_32K = 5;
  localparam int INT_REF_STAT = 4;
  localparam int SRC_STAT_HI = 3;
  localparam int SRC_STAT_LO = 2;
  localparam int OSC_INIT = 1;
  localparam int FINE_TRIM = 0;
  // ****************************************
  // Source codes and loop factors
  // ****************************************
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam logic [10:0] MULT_LOW = 11'h200;
  localparam logic [10:0] MULT_MID = 11'h400;
  localparam logic [10:0] MULT_LOW_32K = 11'h260;
  localparam logic [10:0] MULT_MID_32K = 11'h4c0;
  localparam int DIV_CNT_W = 3;

  typedef enum logic [6:0] {
    CG_LOOP_ENGAGED_INTERNAL = 7'h01,
    CG_LOOP_ENGAGED_EXTERNAL = 7'h02,
    CG_LOOP_BYPASSED_INTERNAL = 7'h04,
    CG_BYPASSED_INTERNAL_LOW_POWER = 7'h08,
    CG_LOOP_BYPASSED_EXTERNAL = 7'h10,
    CG_BYPASSED_EXTERNAL_LOW_POWER = 7'h20,
    CG_STOP = 7'h40
  } cg_mode_t;

  typedef struct packed {
    logic highGain;
    logic rangeHigh;
    logic extRefKind;
    logic extRefEnable;
    logic extRefStopEnable;
  } cg_osc_ctrl_t;
endpackage : cg_pkg

// File: logic/cg_bus_div.sv
`timescale 1ns/1ps
module cg_bus_div #(
  parameter int CNT_W = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic srcTick,
  input wire logic run,
  input wire logic [1:0] divSel,
  output logic clkOut
);
  // ****************************************
  // Divider on an edge stream
  // ****************************************
  // Each srcTick is one source edge; toggling every 2**divSel edges divides by 1, 2, 4 or 8.
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] lastCnt;

  always_comb begin
    lastCnt = CNT_W'((1 << divSel) - 1);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (!run) begin
      cnt_reg <= '0;
    end else if (srcTick) begin
      cnt_reg <= (cnt_reg >= lastCnt) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clkOut <= 1'b0;
    end else if (!run) begin
      clkOut <= 1'b0;
    end else if (srcTick && cnt_reg >= lastCnt) begin
      clkOut <= ~clkOut;
    end
  end
endmodule : cg_bus_div

// File: logic/cg_fll_ctrl.sv
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
// Operation
// - Selected source passes bus divider first
// - Bus divider ratios 1, 2, 4, 8
// - Upper range bits have no effect
// - Loop factor 512/1024 or 608/1216
// - 32768 Hz maximum frequency setting
// - Debug clock is loop divided by two
// - Reset enters loop engaged internal mode
// - Engaged internal: loop output, debug clock
// - Engaged external: loop output, debug clock
// - Bypassed internal: loop runs, internal out
// - Internal low power: loop off, no debug
// - Bypassed external: loop runs, external out
// - External low power: loop off, no debug
// - Stop: no clocks, references per enables
// - Leaving stop resets range and relocks
// - Trim loaded from factory or default
// - Nine trim bits for internal reference
// - Control lines to crystal oscillator
// - All connections are on-chip signals
// - Source select 00 loop, 01 internal, 10 external, 11 reserved
// - Bus divider resets to divide by two
// - Reference select 1 internal, 0 external
// - Low power disables loop in bypass modes unless debugging
module cg_fll_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [cg_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loopClkIn,
  input wire logic intRefClkIn,
  input wire logic extRefClkIn,
  input wire logic oscReadyIn,
  input wire logic debugMode,
  input wire logic stopReq,
  input wire logic [8:0] factoryTrim,
  output logic sysClkOut,
  output logic debugClkOut,
  output logic intRefClkEnable,
  output logic loopEnable,
  output logic loopRefInternal,
  output logic [10:0] loopMultiplier,
  output logic [2:0] refDivSelect,
  output logic [8:0] trimOut,
  output logic loopRelock,
  output cg_pkg::cg_osc_ctrl_t oscCtrl,
  output cg_pkg::cg_mode_t modeOut
);
  // ****************************************
  // Input synchronisers and edge detect
  // ****************************************
  logic [3:0] asyncIn;
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic [3:0] syncC_reg;
  logic loopTick;
  logic intTick;
  logic extTick;
  logic oscReady;

  assign asyncIn = {oscReadyIn, extRefClkIn, intRefClkIn, loopClkIn};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          syncA_reg[gi] <= 1'b0;
          syncB_reg[gi] <= 1'b0;
          syncC_reg[gi] <= 1'b0;
        end else begin
          syncA_reg[gi] <= asyncIn[gi];
          syncB_reg[gi] <= syncA_reg[gi];
          syncC_reg[gi] <= syncB_reg[gi];
        end
      end
    end
  endgenerate

  // Every level change of a source is one source edge
  assign loopTick = syncB_reg[0] ^ syncC_reg[0];
  assign intTick = syncB_reg[1] ^ syncC_reg[1];
  assign extTick = syncB_reg[2] ^ syncC_reg[2];
  assign oscReady = syncB_reg[3];

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] srcCtrl_reg;
  logic [7:0] oscDiv_reg;
  logic [7:0] trim_reg;
  logic [7:0] status_reg;
  logic trimLoadPending_reg;
  logic stopSeen_reg;
  logic loopRelock_reg;
  logic [31:0] prdata_reg;
  logic [1:0] srcActive_reg;
  logic intRefStat_reg;
  logic debugDiv_reg;
  logic debugClk_reg;
  logic wrEn;
  logic rdSetup;
  logic mapped;
  logic [7:0] rdByte;
  logic [1:0] srcSel;
  logic stopMode;
  logic lowPowerOff;
  logic debugAvail;
  logic selTick;
  logic [7:0] wrSrcCtrl;

  assign mapped = (paddr == cg_pkg::OFF_SRC_CTRL) || (paddr == cg_pkg::OFF_OSC_DIV)
               || (paddr == cg_pkg::OFF_TRIM) || (paddr == cg_pkg::OFF_STATUS);
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdSetup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // A write of the reserved source code stores the loop output code
  always_comb begin
    wrSrcCtrl = pwdata[7:0];
    if (pwdata[cg_pkg::SRC_SEL_HI:cg_pkg::SRC_SEL_LO] == cg_pkg::SRC_RSVD) begin
      wrSrcCtrl[cg_pkg::SRC_SEL_HI:cg_pkg::SRC_SEL_LO] = cg_pkg::SRC_LOOP;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      srcCtrl_reg <= cg_pkg::RST_SRC_CTRL;
    end else if (wrEn && paddr == cg_pkg::OFF_SRC_CTRL) begin
      srcCtrl_reg <= wrSrcCtrl;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oscDiv_reg <= cg_pkg::RST_OSC_DIV;
    end else if (wrEn && paddr == cg_pkg::OFF_OSC_DIV) begin
      oscDiv_reg <= pwdata[7:0];
    end
  end

  // Trim is loaded on the first edge after reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trimLoadPending_reg <= 1'b1;
    end else begin
      trimLoadPending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trim_reg <= '0;
    end else if (trimLoadPending_reg) begin
      trim_reg <= debugMode ? cg_pkg::TRIM_DEBUG_DEFAULT[8:1] : factoryTrim[8:1];
    end else if (wrEn && paddr == cg_pkg::OFF_TRIM) begin
      trim_reg <= pwdata[7:0];
    end
  end

  // Range select, 32k option and fine trim; range returns to reset on leaving stop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= cg_pkg::RST_STATUS;
    end else begin
      if (wrEn && paddr == cg_pkg::OFF_STATUS) begin
        status_reg[cg_pkg::OSC_RANGE_HI:cg_pkg::OSC_RANGE_LO] <=
          pwdata[cg_pkg::OSC_RANGE_HI:cg_pkg::OSC_RANGE_LO];
        status_reg[cg_pkg::MAX_32K] <= pwdata[cg_pkg::MAX_32K];
        status_reg[cg_pkg::FINE_TRIM] <= pwdata[cg_pkg::FINE_TRIM];
      end
      if (trimLoadPending_reg) begin
        status_reg[cg_pkg::FINE_TRIM] <= debugMode ?
          cg_pkg::TRIM_DEBUG_DEFAULT[0] : factoryTrim[0];
      end
      if (loopRelock_reg) begin
        status_reg[cg_pkg::OSC_RANGE_HI:cg_pkg::OSC_RANGE_LO] <= 2'h0;
      end
    end
  end

  always_comb begin
    unique case (paddr)
      cg_pkg::OFF_SRC_CTRL: rdByte = srcCtrl_reg;
      cg_pkg::OFF_OSC_DIV: rdByte = oscDiv_reg;
      cg_pkg::OFF_TRIM: rdByte = trim_reg;
      cg_pkg::OFF_STATUS: begin
        rdByte = status_reg;
        rdByte[cg_pkg::OSC_RANGE_HI] = 1'b0;
        rdByte[cg_pkg::INT_REF_STAT] = intRefStat_reg;
        rdByte[cg_pkg::SRC_STAT_HI:cg_pkg::SRC_STAT_LO] = srcActive_reg;
        rdByte[cg_pkg::OSC_INIT] = oscReady;
      end
      default: rdByte = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and stands through the access phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg <= 32'h0;
    end else if (rdSetup) begin
      prdata_reg <= {24'h0, rdByte};
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  assign srcSel = srcCtrl_reg[cg_pkg::SRC_SEL_HI:cg_pkg::SRC_SEL_LO];
  assign stopMode = stopReq;
  assign lowPowerOff = oscDiv_reg[cg_pkg::LOW_POWER] && !debugMode;

  always_comb begin
    if (stopMode) begin
      modeOut = cg_pkg::CG_STOP;
    end else if (srcSel == cg_pkg::SRC_INT) begin
      modeOut = lowPowerOff ? cg_pkg::CG_BYPASSED_INTERNAL_LOW_POWER
                            : cg_pkg::CG_LOOP_BYPASSED_INTERNAL;
    end else if (srcSel == cg_pkg::SRC_EXT) begin
      modeOut = lowPowerOff ? cg_pkg::CG_BYPASSED_EXTERNAL_LOW_POWER
                            : cg_pkg::CG_LOOP_BYPASSED_EXTERNAL;
    end else if (srcCtrl_reg[cg_pkg::INT_REF_SEL]) begin
      modeOut = cg_pkg::CG_LOOP_ENGAGED_INTERNAL;
    end else begin
      modeOut = cg_pkg::CG_LOOP_ENGAGED_EXTERNAL;
    end
  end

  assign loopEnable = !(stopMode || modeOut == cg_pkg::CG_BYPASSED_INTERNAL_LOW_POWER
                     || modeOut == cg_pkg::CG_BYPASSED_EXTERNAL_LOW_POWER);
  assign loopRefInternal = srcCtrl_reg[cg_pkg::INT_REF_SEL];
  assign debugAvail = loopEnable;
  assign refDivSelect = srcCtrl_reg[cg_pkg::REF_DIV_HI:cg_pkg::REF_DIV_LO];
  assign trimOut = {trim_reg, status_reg[cg_pkg::FINE_TRIM]};

  // Only the low bit of range select steers the loop
  always_comb begin
    unique case ({status_reg[cg_pkg::MAX_32K], status_reg[cg_pkg::OSC_RANGE_LO]})
      2'b00: loopMultiplier = cg_pkg::MULT_LOW;
      2'b01: loopMultiplier = cg_pkg::MULT_MID;
      2'b10: loopMultiplier = cg_pkg::MULT_LOW_32K;
      2'b11: loopMultiplier = cg_pkg::MULT_MID_32K;
    endcase
  end

  // Reference enables follow the stop-enable bits while stopped
  assign intRefClkEnable = srcCtrl_reg[cg_pkg::INT_REF_EN]
    && (!stopMode || srcCtrl_reg[cg_pkg::INT_REF_STOP_EN]);
  always_comb begin
    oscCtrl.highGain = oscDiv_reg[cg_pkg::HIGH_GAIN];
    oscCtrl.rangeHigh = oscDiv_reg[cg_pkg::RANGE_BIT];
    oscCtrl.extRefKind = oscDiv_reg[cg_pkg::EXT_REF_KIND];
    oscCtrl.extRefEnable = oscDiv_reg[cg_pkg::EXT_REF_EN]
      && (!stopMode || oscDiv_reg[cg_pkg::EXT_REF_STOP_EN]);
    oscCtrl.extRefStopEnable = oscDiv_reg[cg_pkg::EXT_REF_STOP_EN];
  end

  // ****************************************
  // Stop exit and reference status
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stopSeen_reg <= 1'b0;
    end else begin
      stopSeen_reg <= stopMode;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      loopRelock_reg <= 1'b0;
    end else begin
      loopRelock_reg <= stopSeen_reg && !stopMode;
    end
  end
  assign loopRelock = loopRelock_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      intRefStat_reg <= 1'b1;
    end else begin
      intRefStat_reg <= srcCtrl_reg[cg_pkg::INT_REF_SEL];
    end
  end

  // ****************************************
  // Glitch-free source switch and divider
  // ****************************************
  // The active source changes only while the divided output is low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      srcActive_reg <= cg_pkg::SRC_LOOP;
    end else if (!sysClkOut && srcActive_reg != srcSel) begin
      srcActive_reg <= srcSel;
    end
  end

  always_comb begin
    unique case (srcActive_reg)
      cg_pkg::SRC_INT: selTick = intTick;
      cg_pkg::SRC_EXT: selTick = extTick;
      default: selTick = loopTick;
    endcase
  end

  cg_bus_div #(
    .CNT_W(cg_pkg::DIV_CNT_W)
  ) u_bus_div (
    .mclk(mclk),
    .arst_n(arst_n),
    .srcTick(selTick),
    .run(!stopMode),
    .divSel(oscDiv_reg[cg_pkg::BUS_DIV_HI:cg_pkg::BUS_DIV_LO]),
    .clkOut(sysClkOut)
  );

  // Debug clock toggles every second loop edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      debugDiv_reg <= 1'b0;
      debugClk_reg <= 1'b0;
    end else if (!debugAvail) begin
      debugDiv_reg <= 1'b0;
      debugClk_reg <= 1'b0;
    end else if (loopTick) begin
      debugDiv_reg <= ~debugDiv_reg;
      if (debugDiv_reg) begin
        debugClk_reg <= ~debugClk_reg;
      end
    end
  end
  assign debugClkOut = debugClk_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_src_not_reserved;
    @(posedge mclk) disable iff (!arst_n) srcSel != cg_pkg::SRC_RSVD;
  endproperty
  a_src_not_reserved: assert property (p_src_not_reserved)
    else $error("reserved source select stored");

  property p_low_power_no_debug;
    @(posedge mclk) disable iff (!arst_n)
      (modeOut == cg_pkg::CG_BYPASSED_INTERNAL_LOW_POWER) [*2] |-> !debugClkOut && !loopEnable;
  endproperty
  a_low_power_no_debug: assert property (p_low_power_no_debug)
    else $error("debug clock or loop active in low power bypass");

  property p_stop_no_clock;
    @(posedge mclk) disable iff (!arst_n) stopMode [*2] |-> !sysClkOut && !debugClkOut;
  endproperty
  a_stop_no_clock: assert property (p_stop_no_clock)
    else $error("clock present during stop");

  property p_reset_mode;
    @(posedge mclk) disable iff (!arst_n)
      (srcCtrl_reg == cg_pkg::RST_SRC_CTRL && !stopMode) |-> modeOut == cg_pkg::CG_LOOP_ENGAGED_INTERNAL;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("reset settings do not give engaged internal mode");

  property p_multiplier_32k;
    @(posedge mclk) disable iff (!arst_n)
      status_reg[cg_pkg::MAX_32K] |-> loopMultiplier == cg_pkg::MULT_LOW_32K
        || loopMultiplier == cg_pkg::MULT_MID_32K;
  endproperty
  a_multiplier_32k: assert property (p_multiplier_32k)
    else $error("wrong loop factor with 32k option");

  property p_relock_after_stop;
    @(posedge mclk) disable iff (!arst_n) $fell(stopMode) |=> loopRelock ##1 !loopRelock;
  endproperty
  a_relock_after_stop: assert property (p_relock_after_stop)
    else $error("no single relock pulse after stop");

  property p_trim_debug_default;
    @(posedge mclk) disable iff (!arst_n)
      (trimLoadPending_reg && debugMode) |=> trimOut == cg_pkg::TRIM_DEBUG_DEFAULT;
  endproperty
  a_trim_debug_default: assert property (p_trim_debug_default)
    else $error("debug trim default not loaded");

  property p_debug_clk_from_loop;
    @(posedge mclk) disable iff (!arst_n)
      ($changed(debugClkOut) && debugAvail) |-> $past(loopTick) && $past(debugDiv_reg);
  endproperty
  a_debug_clk_from_loop: assert property (p_debug_clk_from_loop)
    else $error("debug clock not a half rate of loop edges");

  property p_lp_ignored_in_debug;
    @(posedge mclk) disable iff (!arst_n)
      (debugMode && !stopMode) |-> loopEnable;
  endproperty
  a_lp_ignored_in_debug: assert property (p_lp_ignored_in_debug)
    else $error("loop disabled while debugging");
endmodule : cg_fll_ctrl

// File: tb/cg_src_model.sv
`timescale 1ns/1ps
// ****************************************
// Source clocks and oscillator start-up
// ****************************************
module cg_src_model #(
  parameter int LOOP_HALF = 23,
  parameter int INT_HALF = 61,
  parameter int EXT_HALF = 97,
  parameter int OSC_START = 300
) (
  output logic loopClk,
  output logic intClk,
  output logic extClk,
  output logic oscReady
);
  // Periods unrelated to mclk, each edge at least 2 mclk apart
  initial begin
    loopClk = 1'b0;
    forever #LOOP_HALF loopClk = ~loopClk;
  end
  initial begin
    intClk = 1'b0;
    forever #INT_HALF intClk = ~intClk;
  end
  initial begin
    extClk = 1'b0;
    forever #EXT_HALF extClk = ~extClk;
  end
  initial begin
    oscReady = 1'b0;
    #OSC_START oscReady = 1'b1;
  end
endmodule : cg_src_model

// File: tb/tb_fll_clock_source_mode_control.sv
`timescale 1ns/1ps
module tb_fll_clock_source_mode_control;
  // ****************************************
  // Signals and design
  // ****************************************
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic loopClk, intClk, extClk, oscReady, debugMode, stopReq, err;
  logic sysClkOut, debugClkOut, intRefClkEnable, loopEnable, loopRefInternal, loopRelock;
  logic [10:0] loopMultiplier;
  logic [2:0] refDivSelect;
  logic [8:0] trimOut;
  cg_pkg::cg_osc_ctrl_t oscCtrl;
  cg_pkg::cg_mode_t modeOut;
  int n_errors, checked, nSys, nDbg, nSrc;
  int tSys, tDbg, tSrc;
  logic sysPrev, dbgPrev, srcPrev, seen;
  localparam logic [8:0] FINE_TRIM_VAL = 9'h0a5;
  cg_fll_ctrl u_dut (.mclk(mclk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loopClkIn(loopClk), .intRefClkIn(intClk), .extRefClkIn(extClk),
    .oscReadyIn(oscReady), .debugMode(debugMode), .stopReq(stopReq),
    .factoryTrim(FINE_TRIM_VAL), .sysClkOut(sysClkOut), .debugClkOut(debugClkOut),
    .intRefClkEnable(intRefClkEnable), .loopEnable(loopEnable),
    .loopRefInternal(loopRefInternal), .loopMultiplier(loopMultiplier),
    .refDivSelect(refDivSelect), .trimOut(trimOut), .loopRelock(loopRelock),
    .oscCtrl(oscCtrl), .modeOut(modeOut));
  cg_src_model u_src (.loopClk(loopClk), .intClk(intClk), .extClk(extClk),
    .oscReady(oscReady));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Toggle counters for the output clocks and the internal reference clock
  always @(posedge mclk) begin
    sysPrev <= sysClkOut;
    dbgPrev <= debugClkOut;
    srcPrev <= intClk;
    if (sysClkOut !== sysPrev) tSys++;
    if (debugClkOut !== dbgPrev) tDbg++;
    if (intClk !== srcPrev) tSrc++;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR time=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs settle one edge after the access
    @(posedge mclk);
  endtask : apb
  task automatic counts(input int n);
    int s0;
    int d0;
    int c0;
    s0 = tSys;
    d0 = tDbg;
    c0 = tSrc;
    repeat (n) @(posedge mclk);
    nSys = tSys - s0;
    nDbg = tDbg - d0;
    nSrc = tSrc - c0;
  endtask : counts
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #300us;
    n_errors++;
    finish_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  logic [7:0] c1Tab [6] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80};
  logic [7:0] c2Tab [6] = '{8'h40, 8'h40, 8'h40, 8'h48, 8'h40, 8'h48};
  cg_pkg::cg_mode_t mTab [6] = '{cg_pkg::CG_LOOP_ENGAGED_INTERNAL,
    cg_pkg::CG_LOOP_ENGAGED_EXTERNAL, cg_pkg::CG_LOOP_BYPASSED_INTERNAL,
    cg_pkg::CG_BYPASSED_INTERNAL_LOW_POWER, cg_pkg::CG_LOOP_BYPASSED_EXTERNAL,
    cg_pkg::CG_BYPASSED_EXTERNAL_LOW_POWER};
  logic expEn;
  int diff;
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    debugMode = 1'b0;
    stopReq = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check(32'(modeOut), 32'(cg_pkg::CG_LOOP_ENGAGED_INTERNAL));
    check(32'(trimOut), 32'(FINE_TRIM_VAL));
    apb(1'b0, cg_pkg::OFF_SRC_CTRL, 32'h0);
    check(rd, 32'h04);
    apb(1'b0, cg_pkg::OFF_OSC_DIV, 32'h0);
    check(rd, 32'h40);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[31:1], err}, 32'h1);
    apb(1'b1, cg_pkg::OFF_SRC_CTRL, 32'hc4);
    apb(1'b0, cg_pkg::OFF_SRC_CTRL, 32'h0);
    check(rd, 32'h04);
    $display("test registers done");
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, cg_pkg::OFF_SRC_CTRL, {24'h0, c1Tab[m]});
      apb(1'b1, cg_pkg::OFF_OSC_DIV, {24'h0, c2Tab[m]});
      expEn = !(c1Tab[m][7:6] != 2'b00 && c2Tab[m][3]);
      repeat (10) @(posedge mclk);
      counts(80);
      check(32'(modeOut), 32'(mTab[m]));
      check(32'(loopEnable), 32'(expEn));
      check(32'(loopRefInternal), 32'(c1Tab[m][2]));
      check(32'(nDbg > 0), 32'(expEn));
    end
    $display("test modes done");
    apb(1'b1, cg_pkg::OFF_SRC_CTRL, 32'h44);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, cg_pkg::OFF_OSC_DIV, 32'(b << 6));
      repeat (40) @(posedge mclk);
      counts(1200);
      diff = (nSrc >> b) - nSys;
      check(32'(diff >= -1 && diff <= 1 && nSys > 0), 32'h1);
    end
    $display("test divider done");
    apb(1'b1, cg_pkg::OFF_STATUS, 32'he1);
    apb(1'b0, cg_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'he1, 32'h61);
    check(32'(loopMultiplier), 32'(cg_pkg::MULT_MID_32K));
    apb(1'b1, cg_pkg::OFF_STATUS, 32'h20);
    check(32'(loopMultiplier), 32'(cg_pkg::MULT_LOW_32K));
    apb(1'b1, cg_pkg::OFF_STATUS, 32'h00);
    check(32'(loopMultiplier), 32'(cg_pkg::MULT_LOW));
    apb(1'b1, cg_pkg::OFF_STATUS, 32'h40);
    check(32'(loopMultiplier), 32'(cg_pkg::MULT_MID));
    apb(1'b1, cg_pkg::OFF_TRIM, 32'h5a);
    @(posedge mclk);
    check(32'(trimOut[8:1]), 32'h5a);
    apb(1'b1, cg_pkg::OFF_OSC_DIV, 32'h76);
    check(32'(oscCtrl), 32'h1e);
    $display("test controls done");
    apb(1'b1, cg_pkg::OFF_SRC_CTRL, 32'h3e);
    check(32'(refDivSelect), 32'h7);
    stopReq <= 1'b1;
    repeat (10) @(posedge mclk);
    counts(80);
    check(32'(modeOut), 32'(cg_pkg::CG_STOP));
    check({nSys[7:0], nDbg[7:0], 14'h0, loopEnable, intRefClkEnable}, 32'h0);
    check(32'(oscCtrl.extRefEnable), 32'h0);
    apb(1'b1, cg_pkg::OFF_SRC_CTRL, 32'h3f);
    check(32'(intRefClkEnable), 32'h1);
    stopReq <= 1'b0;
    seen = 1'b0;
    repeat (5) begin
      @(posedge mclk);
      if (loopRelock === 1'b1) seen = 1'b1;
    end
    check(32'(seen), 32'h1);
    apb(1'b0, cg_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'hc0, 32'h0);
    check(rd & 32'h1e, 32'h12);
    $display("test stop done");
    debugMode <= 1'b1;
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check(32'(trimOut), 32'(cg_pkg::TRIM_DEBUG_DEFAULT));
    apb(1'b1, cg_pkg::OFF_SRC_CTRL, 32'h44);
    apb(1'b1, cg_pkg::OFF_OSC_DIV, 32'h48);
    check(32'(loopEnable), 32'h1);
    $display("test debug done");
    finish_test();
  end
endmodule : tb_fll_clock_source_mode_control
